// ==== src/clkgen_cfg_pkg.sv ====
// Constants for the clock generator configuration block.
// Assumes a 32-bit APB master on the same clock as the block.
package clkgen_cfg_pkg;
  // Register byte offsets; each profile occupies a bank of eight words.
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_BANK_BASE = 12'h100;
  localparam logic [11:0] OFS_BANK_STRIDE = 12'h040;
  // Word index inside a bank.
  localparam logic [2:0] W_LOOP0 = 3'h0;
  localparam logic [2:0] W_FILT = 3'h4;
  localparam logic [2:0] W_POST = 3'h5;
  localparam logic [2:0] W_SPREAD0 = 3'h6;
  localparam logic [2:0] W_SPREAD1 = 3'h7;
  // Loop word fields.
  localparam int REF_LSB = 0;
  localparam int FB_LSB = 8;
  localparam int PRE_LSB = 19;
  // Filter word: 13 bits per loop, one loop per 16-bit half.
  localparam int FILT_W = 13;
  // Control word fields.
  localparam int CTRL_KEEP_ALIVE = 0;
  localparam int CTRL_XTAL_OFF_N = 1;
  localparam int CTRL_SPREAD_DIS_N = 2;
  // Limits.
  localparam logic [7:0] REF_MIN = 8'h01;
  localparam logic [10:0] FB_MIN = 11'h006;
  localparam logic [7:0] POST_MIN = 8'h01;
  // Reset values.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  localparam logic [31:0] LOOP_RESET = 32'h0000_0a01;
  localparam logic [31:0] POST_RESET = 32'h0101_0101;
  localparam logic [31:0] FILT_RESET = 32'h0000_0000;
  localparam logic [31:0] SPREAD0_RESET = 32'h0000_0000;
  localparam logic [31:0] SPREAD1_RESET = 32'h0000_0000;
  // Nonvolatile restore walks every bank word once.
  localparam int NV_WORDS = 24;
  typedef enum logic [1:0] {MODE_OFF, MODE_RUN} mode_e;
endpackage

// ==== src/clkgen_cfg.sv ====
// Configuration store and profile selector for a four-loop clock generator.
// Assumes an APB master, asynchronous select pins and a nonvolatile image on i_nv_*.
// How it works
// R01: each loop has an 8-bit reference and an 11-bit feedback divider.
// R02: reference 1..255, feedback 6..2047, first loop prescale 1 or 4.
// R03: only the first and fourth loops carry a selectable feedback prescale.
// R04: every output path has its own 8-bit post-divider.
// R05: output equals reference times prescale and feedback over reference and post.
// R06: changing a divider may glitch outputs; host must tolerate it.
// R07: spread modulation exists only on the second loop, host switchable.
// R08: spread runs when the active-low spread disable bit is 0.
// R09: spread holds 11-bit cycle count, 13-bit ratio, 11-bit amplitude.
// R10: cycle count is output pulses per spread period.
// R11: host writes an even count; up and down halves are equal.
// R12: host computes the ratio word from reference, count and mid frequency.
// R13: host computes the amplitude word from count and spread fraction.
// R14: each loop has resistor, zero cap, pole cap and pump current fields.
// R15: the crystal path is active only while its off bit is 0.
// R16: select 00 is low power, 01/10/11 pick profiles zero to two.
// R17: host may rewrite the profile registers while running.
// R18: low power with keep-alive 0 shuts all; 1 keeps 32 kHz on pin two.
// R19: host must not present select 00 at power-on.
// R20: after reset the nonvolatile image loads before the bus is served.
// R21: select pins are synchronised before they change the profile.
// R22: a profile change loads all its fields in one cycle.
//
// Implementation choices: the APB register port and the register offsets.
module clkgen_cfg (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_cfg_pin_low,
  input wire logic i_cfg_pin_high,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [4:0] o_nv_addr,
  input wire logic [31:0] i_nv_data,
  output logic o_restore_busy,
  output logic [87:0] o_loop_dividers,
  output logic [51:0] o_loop_filter,
  output logic [47:0] o_output_post_divider,
  output logic [10:0] o_spread_cycle_count,
  output logic [12:0] o_spread_ratio_word,
  output logic [10:0] o_spread_amplitude_word,
  output logic o_spread_on,
  output logic o_crystal_on,
  output logic o_outputs_on,
  output logic o_clock_pin_two_sleep,
  output logic [1:0] o_active_profile
);
  // Bank storage: three profiles of eight words each.
  logic [31:0] bank_reg [0:23];
  logic [31:0] bank_next [0:23];
  logic [31:0] ctrl_reg, ctrl_next;
  logic [1:0] sel_meta_reg, sel_sync_reg, sel_meta_next, sel_sync_next;
  logic [1:0] sel_prev_reg, sel_prev_next;
  logic [4:0] nv_idx_reg, nv_idx_next;
  clkgen_cfg_pkg::mode_e mode_reg, mode_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;
  logic [87:0] div_next;
  logic [51:0] filt_next;
  logic [47:0] post_next;
  logic [10:0] nc_next, nss_next;
  logic [12:0] ratio_next;
  logic spread_next, xtal_next, out_next, sleep_next;
  logic [1:0] prof_next;

  // Bank word index for a byte address, or 5'h1f when unmapped.
  function automatic logic [4:0] bank_index(input logic [11:0] addr);
    logic [11:0] rel;
    rel = addr - clkgen_cfg_pkg::OFS_BANK_BASE;
    if (addr < clkgen_cfg_pkg::OFS_BANK_BASE || rel[1:0] != 2'h0 || rel[5] == 1'b1 || rel[11:6] > 6'h02) begin
      return 5'h1f;
    end
    return 5'(rel[7:6] * 4'h8 + rel[4:2]);
  endfunction

  // Clamp a loop word into legal ranges, so a bad write never reaches the analog side.
  function automatic logic [21:0] legal_loop(input logic [31:0] w, input logic has_pre);
    logic [7:0] r;
    logic [10:0] f;
    logic [2:0] p;
    r = w[clkgen_cfg_pkg::REF_LSB +: 8];
    f = w[clkgen_cfg_pkg::FB_LSB +: 11];
    p = w[clkgen_cfg_pkg::PRE_LSB +: 3];
    if (r < clkgen_cfg_pkg::REF_MIN) r = clkgen_cfg_pkg::REF_MIN; // see R02
    if (f < clkgen_cfg_pkg::FB_MIN) f = clkgen_cfg_pkg::FB_MIN; // see R02
    if (!has_pre) begin
      p = 3'h0; // see R03
    end
    return {p, f, r};
  endfunction

  always_comb begin
    logic [4:0] idx;
    logic [4:0] base;
    logic xfer;
    idx = bank_index(i_paddr);
    base = 5'h00;
    xfer = i_psel && i_penable;
    for (int k = 0; k < 24; k++) begin
      bank_next[k] = bank_reg[k];
    end
    ctrl_next = ctrl_reg;
    nv_idx_next = nv_idx_reg;
    mode_next = mode_reg;
    prdata_next = 32'h0000_0000;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    sel_meta_next = {i_cfg_pin_high, i_cfg_pin_low};
    sel_sync_next = sel_meta_reg; // see R21
    sel_prev_next = sel_sync_reg;
    case (mode_reg)
      clkgen_cfg_pkg::MODE_OFF: begin
        bank_next[nv_idx_reg] = i_nv_data; // see R20
        nv_idx_next = 5'(nv_idx_reg + 5'h01);
        if (nv_idx_reg == 5'(clkgen_cfg_pkg::NV_WORDS - 1)) begin
          mode_next = clkgen_cfg_pkg::MODE_RUN;
        end
      end
      clkgen_cfg_pkg::MODE_RUN: begin
        // One wait state: the answer comes in the second access cycle.
        // A write lands only at the edge that completes the transfer, so an aborted access changes nothing.
        if (xfer && !o_pready) begin
          pready_next = 1'b1;
          if (i_paddr == clkgen_cfg_pkg::OFS_CTRL) begin
            prdata_next = {29'h0, ctrl_reg[2:0]};
          end else if (i_paddr == clkgen_cfg_pkg::OFS_STATUS) begin
            prdata_next = {27'h0, o_outputs_on, o_clock_pin_two_sleep, o_spread_on, o_active_profile};
            pslverr_next = i_pwrite;
          end else if (idx != 5'h1f) begin
            prdata_next = bank_reg[idx];
          end else begin
            pslverr_next = 1'b1;
          end
        end else if (xfer && i_pwrite) begin
          if (i_paddr == clkgen_cfg_pkg::OFS_CTRL) begin
            ctrl_next = {29'h0, i_pwdata[2:0]};
          end else if (i_paddr != clkgen_cfg_pkg::OFS_STATUS && idx != 5'h1f) begin
            bank_next[idx] = i_pwdata; // see R17 R06
          end
        end
      end
      default: mode_next = clkgen_cfg_pkg::MODE_OFF;
    endcase
    // Active outputs: all fields of the selected bank are taken in the same cycle.
    case (sel_sync_reg) // see R16
      2'b01: base = 5'h00;
      2'b10: base = 5'h08;
      2'b11: base = 5'h10;
      default: base = 5'h00;
    endcase
    for (int l = 0; l < 4; l++) begin
      div_next[l * 22 +: 22] = legal_loop(bank_reg[base + 5'(l)], l == 0 || l == 3); // see R01 R22
      filt_next[l * 13 +: 13] = (l < 2) ? bank_reg[base + 5'(clkgen_cfg_pkg::W_FILT)][l * 16 +: 13]
                                        : bank_reg[base + 5'(clkgen_cfg_pkg::W_POST) + 5'h02][(l - 2) * 16 + 3 +: 13]; // see R14
    end
    // First loop prescale is either 1 or 4: any nonzero code means 4.
    div_next[19 +: 3] = (div_next[19 +: 3] != 3'h0) ? 3'h4 : 3'h1; // see R02 R05
    for (int o = 0; o < 6; o++) begin
      post_next[o * 8 +: 8] = (o < 4) ? bank_reg[base + 5'(clkgen_cfg_pkg::W_POST)][o * 8 +: 8]
                                      : bank_reg[base + 5'(clkgen_cfg_pkg::W_SPREAD1)][(o - 4) * 8 + 16 +: 8];
      if (post_next[o * 8 +: 8] < clkgen_cfg_pkg::POST_MIN) post_next[o * 8 +: 8] = clkgen_cfg_pkg::POST_MIN; // see R04
    end
    // Odd cycle counts are rounded down so both halves of the period match.
    nc_next = {bank_reg[base + 5'(clkgen_cfg_pkg::W_SPREAD0)][10:1], 1'b0}; // see R09 R10 R11
    ratio_next = bank_reg[base + 5'(clkgen_cfg_pkg::W_SPREAD0)][28:16]; // see R12
    nss_next = bank_reg[base + 5'(clkgen_cfg_pkg::W_SPREAD1)][10:0]; // see R13
    spread_next = !ctrl_reg[clkgen_cfg_pkg::CTRL_SPREAD_DIS_N]; // see R07 R08
    xtal_next = !ctrl_reg[clkgen_cfg_pkg::CTRL_XTAL_OFF_N]; // see R15
    out_next = (mode_reg == clkgen_cfg_pkg::MODE_RUN) && (sel_sync_reg != 2'b00);
    sleep_next = (sel_sync_reg == 2'b00) && ctrl_reg[clkgen_cfg_pkg::CTRL_KEEP_ALIVE]; // see R18 R19
    prof_next = (sel_sync_reg == 2'b00) ? 2'b00 : 2'(sel_sync_reg - 2'b01);
    if (sel_sync_reg == 2'b00) begin
      spread_next = 1'b0;
      xtal_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < 24; k++) begin
        bank_reg[k] <= clkgen_cfg_pkg::FILT_RESET;
      end
      ctrl_reg <= clkgen_cfg_pkg::CTRL_RESET;
      sel_meta_reg <= 2'b01;
      sel_sync_reg <= 2'b01;
      sel_prev_reg <= 2'b01;
      nv_idx_reg <= 5'h00;
      mode_reg <= clkgen_cfg_pkg::MODE_OFF;
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_nv_addr <= 5'h00;
      o_restore_busy <= 1'b1;
      o_loop_dividers <= 88'h0;
      o_loop_filter <= 52'h0;
      o_output_post_divider <= 48'h0;
      o_spread_cycle_count <= 11'h000;
      o_spread_ratio_word <= 13'h0000;
      o_spread_amplitude_word <= 11'h000;
      o_spread_on <= 1'b0;
      o_crystal_on <= 1'b0;
      o_outputs_on <= 1'b0;
      o_clock_pin_two_sleep <= 1'b0;
      o_active_profile <= 2'b00;
    end else begin
      for (int k = 0; k < 24; k++) begin
        bank_reg[k] <= bank_next[k];
      end
      ctrl_reg <= ctrl_next;
      sel_meta_reg <= sel_meta_next;
      sel_sync_reg <= sel_sync_next;
      sel_prev_reg <= sel_prev_next;
      nv_idx_reg <= nv_idx_next;
      mode_reg <= mode_next;
      o_prdata <= prdata_next;
      o_pready <= pready_next;
      o_pslverr <= pslverr_next;
      o_nv_addr <= nv_idx_next;
      // Busy drops together with the first outputs taken in run mode; the crystal output is not gated by restore and may already be on while busy.
      o_restore_busy <= (mode_reg == clkgen_cfg_pkg::MODE_OFF);
      o_loop_dividers <= div_next;
      o_loop_filter <= filt_next;
      o_output_post_divider <= post_next;
      o_spread_cycle_count <= nc_next;
      o_spread_ratio_word <= ratio_next;
      o_spread_amplitude_word <= nss_next;
      o_spread_on <= spread_next && out_next;
      o_crystal_on <= xtal_next;
      o_outputs_on <= out_next;
      o_clock_pin_two_sleep <= sleep_next;
      o_active_profile <= prof_next;
    end
  end
endmodule // clkgen_cfg

// ==== sim/nv_image_model.sv ====
// Model of the nonvolatile image that feeds the restore walk.
// Assumes the word is taken in the cycle in which its index is shown.
module nv_image_model (
  input logic i_clk,
  input logic i_busy,
  input logic [4:0] i_addr,
  output logic [31:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stale_reg = 1'b0;
  // Word k holds k; once the walk is over the data toggles, so stale reads show up.
  always_ff @(posedge i_clk) begin
    stale_reg <= ~stale_reg;
  end
  always_comb begin
    o_data = i_busy ? {27'h0, i_addr} : {32{stale_reg}};
  end
endmodule // nv_image_model

// ==== sim/clkgen_cfg_checker.sv ====
// Port checker for the configuration block.
// Assumes one clock and an asynchronous active-high reset.
module clkgen_cfg_checker (
  input logic i_clk,
  input logic i_reset,
  input logic i_psel,
  input logic i_penable,
  input logic i_cfg_pin_low,
  input logic i_cfg_pin_high,
  input logic o_pready,
  input logic o_restore_busy,
  input logic o_spread_on,
  input logic o_crystal_on,
  input logic o_outputs_on,
  input logic o_clock_pin_two_sleep,
  input logic [10:0] o_spread_cycle_count,
  input logic [1:0] o_active_profile
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  AST_RESTORE_HOLD: assert property ($fell(i_reset) |-> o_restore_busy [*8])
    else $error("restore ended too soon");
  AST_QUIET_RESTORE: assert property (o_restore_busy |-> !o_pready)
    else $error("bus answered during restore");
  AST_ONE_WAIT: assert property (i_psel && i_penable && !o_pready && !o_restore_busy |=> o_pready)
    else $error("bus answer late");
  AST_READY_PULSE: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  AST_LOW_POWER_OFF: assert property (!o_outputs_on && !o_restore_busy |-> !o_spread_on && !o_crystal_on)
    else $error("low power left a source on");
  AST_SLEEP_ONLY_OFF: assert property (o_clock_pin_two_sleep |-> !o_outputs_on)
    else $error("sleep while outputs on");
  AST_EVEN_COUNT: assert property (o_spread_cycle_count[0] == 1'b0)
    else $error("odd spread count");
  AST_PIN_SYNC: assert property ($changed({i_cfg_pin_high, i_cfg_pin_low}) |=> $stable(o_active_profile))
    else $error("profile followed pins at once");
  AST_PROFILE_DECODE: assert property ((!o_restore_busy && {i_cfg_pin_high, i_cfg_pin_low} == 2'b10) [*4]
    |-> o_active_profile == 2'd1 && o_outputs_on) else $error("pins 10 not decoded");
endmodule // clkgen_cfg_checker
bind clkgen_cfg clkgen_cfg_checker chk_u (.i_clk, .i_reset, .i_psel, .i_penable, .i_cfg_pin_low, .i_cfg_pin_high,
  .o_pready, .o_restore_busy, .o_spread_on, .o_crystal_on, .o_outputs_on, .o_clock_pin_two_sleep,
  .o_spread_cycle_count, .o_active_profile);

// ==== sim/tb_top.sv ====
// Self-checking bench for the configuration block.
// Assumes the restore image model and the bound checker.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_cfg_pin_low = 1'b1;
  logic i_cfg_pin_high = 1'b0;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, o_pready, o_pslverr, o_restore_busy, err;
  logic o_spread_on, o_crystal_on, o_outputs_on, o_clock_pin_two_sleep;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, i_nv_data, rd;
  logic [4:0] o_nv_addr;
  logic [87:0] o_loop_dividers;
  logic [51:0] o_loop_filter;
  logic [47:0] o_output_post_divider;
  logic [10:0] o_spread_cycle_count, o_spread_amplitude_word;
  logic [12:0] o_spread_ratio_word;
  logic [1:0] o_active_profile;
  int n_errors = 0;
  int num_checks = 0;
  clkgen_cfg dut_u (.i_clk, .i_reset, .i_cfg_pin_low, .i_cfg_pin_high, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_nv_addr, .i_nv_data, .o_restore_busy, .o_loop_dividers,
    .o_loop_filter, .o_output_post_divider, .o_spread_cycle_count, .o_spread_ratio_word, .o_spread_amplitude_word,
    .o_spread_on, .o_crystal_on, .o_outputs_on, .o_clock_pin_two_sleep, .o_active_profile);
  nv_image_model nv_u (.i_clk, .i_busy(o_restore_busy), .i_addr(o_nv_addr), .o_data(i_nv_data));
  initial forever #20 i_clk = ~i_clk;
  task automatic check(input logic [87:0] seen, input logic [87:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // The master waits for ready with no assumed latency; restore may stall it.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 100);
    if (o_pready !== 1'b1) n_errors++;
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic pins(input logic [1:0] p);
    @(posedge i_clk);
    i_cfg_pin_high <= p[1];
    i_cfg_pin_low <= p[0];
    repeat (5) @(posedge i_clk);
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge i_clk);
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    #1;
    check(o_restore_busy, 1'b1);
    xfer(1'b0, clkgen_cfg_pkg::OFS_CTRL, 32'h0);
    check({rd, o_spread_on}, {clkgen_cfg_pkg::CTRL_RESET, 1'b0});
    check({o_loop_dividers[84:66], o_loop_dividers[18:0]}, {11'h006, 8'h03, 11'h006, 8'h01});
    xfer(1'b1, 12'h100, 32'h0000_3405);
    check(o_loop_dividers[18:0], {11'h034, 8'h05});
    xfer(1'b1, 12'h104, 32'h0000_0300);
    check(o_loop_dividers[40:22], {11'h006, 8'h01});
    xfer(1'b1, 12'h110, 32'h1fff_0abc);
    check(o_loop_filter[25:0], {13'h1fff, 13'h0abc});
    xfer(1'b1, 12'h114, 32'h0400_0a00);
    check(o_output_post_divider[31:0], 32'h0401_0a01);
    // Ratio 296 and amplitude 322 follow from 25 MHz in, 27 MHz mid, 640 pulses, 2 percent.
    xfer(1'b1, 12'h118, 32'h0128_0281);
    xfer(1'b1, 12'h11c, 32'h0000_0142);
    check({o_spread_cycle_count, o_spread_ratio_word}, {11'h280, 13'h128});
    check({o_spread_amplitude_word, o_output_post_divider[47:32]}, {11'h142, 16'h0101});
    xfer(1'b1, clkgen_cfg_pkg::OFS_CTRL, 32'h0);
    check({o_spread_on, o_crystal_on}, 2'b11);
    xfer(1'b0, clkgen_cfg_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h0000_0014);
    xfer(1'b1, clkgen_cfg_pkg::OFS_CTRL, 32'h0000_0006);
    check({o_spread_on, o_crystal_on}, 2'b00);
    xfer(1'b1, clkgen_cfg_pkg::OFS_STATUS, 32'h0);
    check(err, 1'b1);
    xfer(1'b0, 12'h0f0, 32'h0);
    check(err, 1'b1);
    xfer(1'b1, 12'h140, 32'h0000_0702);
    pins(2'b10);
    check({o_active_profile, o_loop_dividers[18:0]}, {2'd1, 11'h007, 8'h02});
    check({o_spread_cycle_count, o_loop_filter[12:0]}, {11'h00e, 13'h000c});
    xfer(1'b1, clkgen_cfg_pkg::OFS_CTRL, 32'h0000_0001);
    pins(2'b00);
    check({o_outputs_on, o_clock_pin_two_sleep, o_spread_on, o_crystal_on}, 4'b0100);
    xfer(1'b1, clkgen_cfg_pkg::OFS_CTRL, 32'h0);
    check({o_outputs_on, o_clock_pin_two_sleep}, 2'b00);
    pins(2'b11);
    check({o_active_profile, o_outputs_on}, {2'd2, 1'b1});
    stop_test();
  end
endmodule // tb_top
